// file: ceru_pkg.sv
package ceru_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [4:0]  ADDR_STATUS     = 5'h00;
	localparam logic [4:0]  ADDR_ERROR_CODE = 5'h04;
	localparam logic [4:0]  ADDR_LOG_ADV    = 5'h08;
	localparam logic [4:0]  ADDR_IRQ_STATUS = 5'h0C;
	localparam logic [4:0]  ADDR_IRQ_MASK   = 5'h10;
	localparam logic [4:0]  ADDR_LOG_COUNT  = 5'h14;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int          STAT_GLOBAL_ERR = 0;
	localparam int          STAT_RUN        = 1;
	localparam int          STAT_UNIT_FAULT = 2;
	localparam int          STAT_HOST_FAULT = 3;
	localparam int          STAT_HALTED     = 4;
	localparam int          STAT_LOG_FULL   = 5;
	localparam int          STAT_CAT_LSB    = 8;
	localparam int          STAT_STATE_LSB  = 12;
	localparam int          CODE_SEC_LSB    = 16;

	localparam int          IRQ_NUM         = 4;
	localparam int          IRQ_FAULT       = 0;
	localparam int          IRQ_CLEARED     = 1;
	localparam int          IRQ_LOG_FULL    = 2;
	localparam int          IRQ_WATCHDOG    = 3;

	// ----------------------------------------------------------------
	// Reset values and sizes
	// ----------------------------------------------------------------
	localparam int          LOG_DEPTH       = 30;
	localparam int          CODE_W          = 16;
	localparam logic [31:0] RD_UNMAPPED     = 32'h0000_0000;
	localparam logic [3:0]  IRQ_MASK_RESET  = 4'h0;
	localparam logic [15:0] CODE_ZERO       = 16'h0000;

	// ----------------------------------------------------------------
	// Fault categories and operating phases
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		CAT_CONFIG   = 2'h0,
		CAT_OVERFLOW = 2'h1,
		CAT_PRESET   = 2'h2,
		CAT_SYSTEM   = 2'h3
	} ceru_cat_t;

	typedef enum logic [3:0]
	{
		ST_INIT  = 4'b0001,
		ST_RUN   = 4'b0010,
		ST_HALT  = 4'b0100,
		ST_WDOG  = 4'b1000
	} ceru_state_t;

endpackage

// file: ceru_log.sv
`timescale 1ns/1ps

module ceru_log
	import ceru_pkg::*;
#(
	parameter int DEPTH = LOG_DEPTH,
	parameter int WIDTH = 2 * CODE_W
)
(
	// Clock and reset
	input  wire logic                     clk_sys,
	input  wire logic                     rstn,
	// Control
	input  wire logic                     clear,
	input  wire logic                     wr_en,
	input  wire logic [WIDTH-1:0]         wr_data,
	input  wire logic [$clog2(DEPTH):0]   rd_idx,
	// Status
	output logic      [WIDTH-1:0]         rd_data,
	output logic      [$clog2(DEPTH):0]   count,
	output logic                          full
);

	logic [WIDTH-1:0] mem [DEPTH];

	assign full    = (count == ($clog2(DEPTH)+1)'(DEPTH));
	assign rd_data = (rd_idx < count) ? mem[rd_idx[$clog2(DEPTH)-1:0]] : '0;

	// ----------------------------------------------------------------
	// Append in order of arrival, freeze when full
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			count <= '0;
		else if (clear)
			count <= '0;
		else if (wr_en && !full)
			count <= count + 1'b1;
	end

	always_ff @(posedge clk_sys)
	begin
		if (wr_en && !full && !clear)
			mem[count[$clog2(DEPTH)-1:0]] <= wr_data;
	end

endmodule

// file: ceru_top.sv
//
// Overview of operation
// - Init: bad unit number or cyclic init fault shows run off, unit off, host on.
// - Init: invalid settings show run off, unit fault on, host fault off.
// - Init: wrong unit type shows run off, unit fault on, host fault on.
// - Watchdog expiry turns run, unit fault and host fault all off.
// - Running: overflow, underflow or preset fault shows run on, unit on, host off.
// - Running: host CPU fault shows run on, unit fault off, host fault on.
// - Faults fall into four categories, each identified by two code words.
// - A fault outside the watchdog state loads codes, is logged, sets global flag, lights unit fault.
// - Fault removal clears codes, global flag and unit fault indicator, except in the halt state.
// - Up to thirty faults are logged in order of occurrence.
// - Each rising edge of log advance request presents the next logged fault.
// - Advancing past the last entry presents zero codes.
// - After the zero, advancing restarts from the first log entry.
// - Config faults at init are stored and halt counting.
//
// Decided for this implementation: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps

module ceru_top
	import ceru_pkg::*;
#(
	parameter int DEPTH = LOG_DEPTH
)
(
	// Clock and reset
	input  wire logic              clk_sys,
	input  wire logic              rstn,
	// Avalon-MM slave
	input  wire logic [4:0]        avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	input  wire logic [3:0]        avs_byteenable,
	output logic      [31:0]       avs_readdata,
	output logic                   avs_waitrequest,
	// Initialisation checks
	input  wire logic              unit_restart,
	input  wire logic              init_done,
	input  wire logic              unit_number_bad,
	input  wire logic              cyclic_init_fault,
	input  wire logic              unit_type_wrong,
	input  wire logic              watchdog_expired,
	// Host CPU faults
	input  wire logic              host_fault,
	// Fault reports
	input  wire logic              fault_report,
	input  wire logic [1:0]        fault_category,
	input  wire logic [15:0]       fault_code_primary,
	input  wire logic [15:0]       fault_code_secondary,
	input  wire logic              fault_removed,
	// Indicators and control
	output logic                   run_indicator,
	output logic                   unit_fault_indicator,
	output logic                   host_fault_indicator,
	output logic                   counting_halt,
	output logic                   irq
);

	localparam int IW = $clog2(DEPTH) + 1;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	ceru_state_t             state;
	ceru_state_t             next_state;
	logic                    global_error_flag;
	logic [15:0]             error_code_primary;
	logic [15:0]             error_code_secondary;
	logic [1:0]              last_category;
	logic                    log_advance_request;
	logic                    adv_prev;
	logic [IW-1:0]           rd_idx;
	logic [IRQ_NUM-1:0]      irq_status;
	logic [IRQ_NUM-1:0]      irq_mask;
	logic [31:0]             log_word;
	logic [IW-1:0]           log_count;
	logic                    log_full;
	logic                    log_full_prev;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	wire        bus_req    = avs_read | avs_write;
	wire        rd_take    = avs_read & avs_waitrequest;
	wire        wr_accept  = avs_write & ~avs_waitrequest;
	wire        wr_adv     = wr_accept & (avs_address == ADDR_LOG_ADV) & avs_byteenable[0];
	wire        wr_irq_st  = wr_accept & (avs_address == ADDR_IRQ_STATUS) & avs_byteenable[0];
	wire        wr_irq_msk = wr_accept & (avs_address == ADDR_IRQ_MASK) & avs_byteenable[0];

	// ----------------------------------------------------------------
	// Fault classification
	// ----------------------------------------------------------------
	wire        in_init    = (state == ST_INIT) | (state == ST_HALT);
	wire        cat_config = (fault_category == CAT_CONFIG);
	wire        take_fault = fault_report & (state != ST_WDOG);
	wire        cfg_fault  = take_fault & cat_config & (state == ST_INIT);
	wire        restart    = unit_restart;
	wire        adv_edge   = log_advance_request & ~adv_prev;
	wire [31:0] new_entry  = {fault_code_secondary, fault_code_primary};

	// ----------------------------------------------------------------
	// Indicator patterns
	// ----------------------------------------------------------------
	wire        init_host  = unit_number_bad | cyclic_init_fault | unit_type_wrong;
	wire        init_unit  = global_error_flag | unit_type_wrong;
	wire        next_run   = (state == ST_RUN);
	wire        next_unit  = (state == ST_WDOG) ? 1'b0 :
	                         in_init ? init_unit : global_error_flag;
	wire        next_host  = (state == ST_WDOG) ? 1'b0 :
	                         in_init ? init_host : host_fault;

	// ----------------------------------------------------------------
	// Interrupt events
	// ----------------------------------------------------------------
	wire [IRQ_NUM-1:0] irq_event;
	assign irq_event[IRQ_FAULT]    = take_fault;
	assign irq_event[IRQ_CLEARED]  = fault_removed & global_error_flag;
	assign irq_event[IRQ_LOG_FULL] = log_full & ~log_full_prev;
	assign irq_event[IRQ_WATCHDOG] = watchdog_expired & (state != ST_WDOG);

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	wire [31:0] rd_status  = {16'h0000,
	                          4'(state),
	                          2'b00, last_category,
	                          2'b00, log_full, counting_halt,
	                          host_fault_indicator, unit_fault_indicator,
	                          run_indicator, global_error_flag};
	wire [31:0] rd_code    = {error_code_secondary, error_code_primary};
	wire [31:0] rd_mux     = (avs_address == ADDR_STATUS)     ? rd_status :
	                         (avs_address == ADDR_ERROR_CODE) ? rd_code :
	                         (avs_address == ADDR_LOG_ADV)    ? {31'h0000_0000, log_advance_request} :
	                         (avs_address == ADDR_IRQ_STATUS) ? {28'h000_0000, irq_status} :
	                         (avs_address == ADDR_IRQ_MASK)   ? {28'h000_0000, irq_mask} :
	                         (avs_address == ADDR_LOG_COUNT)  ? {{(32-IW){1'b0}}, log_count} :
	                         RD_UNMAPPED;

	// ----------------------------------------------------------------
	// Operating phase
	// ----------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		unique case (state)
			ST_INIT:
			begin
				if (cfg_fault)
					next_state = ST_HALT;
				else if (init_done && !init_host)
					next_state = ST_RUN;
			end
			ST_RUN:
			begin
				next_state = ST_RUN;
			end
			ST_HALT:
			begin
				next_state = ST_HALT;
			end
			ST_WDOG:
			begin
				next_state = ST_WDOG;
			end
		endcase
		if (restart && state != ST_WDOG)
			next_state = ST_INIT;
		if (watchdog_expired)
			next_state = ST_WDOG;
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			state <= ST_INIT;
		else
			state <= next_state;
	end

	// ----------------------------------------------------------------
	// Bus handshake: one wait cycle, then answer
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
		end
		else
		begin
			avs_waitrequest <= ~(bus_req & avs_waitrequest);
			if (rd_take)
				avs_readdata <= rd_mux;
		end
	end

	// ----------------------------------------------------------------
	// Log advance request register and edge detect
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			log_advance_request <= 1'b0;
			adv_prev            <= 1'b0;
		end
		else
		begin
			if (wr_adv)
				log_advance_request <= avs_writedata[0];
			adv_prev <= log_advance_request;
		end
	end

	// ----------------------------------------------------------------
	// Error flag, codes and log read pointer
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			global_error_flag    <= 1'b0;
			error_code_primary   <= CODE_ZERO;
			error_code_secondary <= CODE_ZERO;
			last_category        <= 2'h0;
			rd_idx               <= '0;
		end
		else if (restart)
		begin
			global_error_flag    <= 1'b0;
			error_code_primary   <= CODE_ZERO;
			error_code_secondary <= CODE_ZERO;
			rd_idx               <= '0;
		end
		else if (take_fault)
		begin
			global_error_flag    <= 1'b1;
			error_code_primary   <= fault_code_primary;
			error_code_secondary <= fault_code_secondary;
			last_category        <= fault_category;
		end
		else if (adv_edge)
		begin
			error_code_primary   <= log_word[15:0];
			error_code_secondary <= log_word[31:16];
			if (rd_idx < log_count)
				rd_idx <= rd_idx + 1'b1;
			else
				rd_idx <= '0;
		end
		else if (fault_removed && state != ST_HALT)
		begin
			global_error_flag    <= 1'b0;
			error_code_primary   <= CODE_ZERO;
			error_code_secondary <= CODE_ZERO;
		end
	end

	// ----------------------------------------------------------------
	// Fault log
	// ----------------------------------------------------------------
	ceru_log #(
		.DEPTH   (DEPTH),
		.WIDTH   (32)
	) u_log (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.clear   (restart),
		.wr_en   (take_fault),
		.wr_data (new_entry),
		.rd_idx  (rd_idx),
		.rd_data (log_word),
		.count   (log_count),
		.full    (log_full)
	);

	// ----------------------------------------------------------------
	// Interrupt status and mask
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			irq_status    <= '0;
			irq_mask      <= IRQ_MASK_RESET;
			log_full_prev <= 1'b0;
		end
		else
		begin
			log_full_prev <= log_full;
			irq_status    <= (irq_status & ~(wr_irq_st ? avs_writedata[IRQ_NUM-1:0] : '0)) | irq_event;
			if (wr_irq_msk)
				irq_mask <= avs_writedata[IRQ_NUM-1:0];
		end
	end

	// ----------------------------------------------------------------
	// Registered outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			run_indicator        <= 1'b0;
			unit_fault_indicator <= 1'b0;
			host_fault_indicator <= 1'b0;
			counting_halt        <= 1'b1;
			irq                  <= 1'b0;
		end
		else
		begin
			run_indicator        <= next_run;
			unit_fault_indicator <= next_unit;
			host_fault_indicator <= next_host;
			counting_halt        <= (next_state != ST_RUN);
			irq                  <= |(irq_status & irq_mask);
		end
	end

endmodule

// file: ceru_host.sv
`timescale 1ns/1ps

module ceru_host
	import ceru_pkg::*;
(
	// Clock
	input  wire logic        clk_sys,
	// Avalon-MM master
	output logic      [4:0]  avs_address,
	output logic             avs_read,
	output logic             avs_write,
	output logic      [31:0] avs_writedata,
	output logic      [3:0]  avs_byteenable,
	input  wire logic [31:0] avs_readdata,
	input  wire logic        avs_waitrequest
);
	initial
	begin
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'hf;
	end

	// Request stands until waitrequest is sampled low at a rising edge
	task automatic xfer(input logic [4:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_sys);
		avs_address <= a;
		avs_read <= !w;
		avs_write <= w;
		avs_writedata <= d;
		do
			@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		avs_writedata <= ~d;
	endtask

	// One step through the log: the request bit goes low, then high
	task automatic advance();
		logic [31:0] q;
		xfer(ADDR_LOG_ADV, 1'b1, 32'h0000_0000, q);
		xfer(ADDR_LOG_ADV, 1'b1, 32'h0000_0001, q);
	endtask
endmodule

// file: ceru_top_chk.sv
`timescale 1ns/1ps

module ceru_top_chk
	import ceru_pkg::*;
#(
	parameter int DEPTH = LOG_DEPTH
)
(
	input wire logic        clk_sys,
	input wire logic        rstn,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        init_done,
	input wire logic        unit_type_wrong,
	input wire logic        watchdog_expired,
	input wire logic        host_fault,
	input wire logic        fault_report,
	input wire logic        run_indicator,
	input wire logic        unit_fault_indicator,
	input wire logic        host_fault_indicator,
	input wire logic        counting_halt,
	input wire logic        irq
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low longer than one cycle");
	wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("request not answered next cycle");
	wait_idle_a: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
		else $error("answer without request");
	rd_hold_a: assert property (avs_waitrequest |-> $stable(avs_readdata))
		else $error("read data changed outside an answer");
	wdog_dark_a: assert property (watchdog_expired |=> ##2 !run_indicator && !unit_fault_indicator && !host_fault_indicator)
		else $error("indicators lit after watchdog");
	fault_lit_a: assert property (fault_report && !counting_halt && !host_fault |-> ##2 unit_fault_indicator)
		else $error("unit fault indicator not lit");
	host_lit_a: assert property ((host_fault && !counting_halt)[*3] |-> host_fault_indicator && run_indicator)
		else $error("host fault not shown");
	type_wrong_a: assert property ((unit_type_wrong && !init_done && !watchdog_expired)[*3] |-> !run_indicator && unit_fault_indicator && host_fault_indicator)
		else $error("unit type fault not shown");
	halt_dark_a: assert property (counting_halt[*3] |-> !run_indicator)
		else $error("run lit while halted");

	cover property (fault_report && !counting_halt);
	cover property (avs_read && !avs_waitrequest);
	cover property ($rose(irq));
	cover property (watchdog_expired);
endmodule

bind ceru_top ceru_top_chk #(.DEPTH(DEPTH)) chk_u (.clk_sys(clk_sys), .rstn(rstn), .avs_read(avs_read),
	.avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.init_done(init_done), .unit_type_wrong(unit_type_wrong), .watchdog_expired(watchdog_expired),
	.host_fault(host_fault), .fault_report(fault_report), .run_indicator(run_indicator),
	.unit_fault_indicator(unit_fault_indicator), .host_fault_indicator(host_fault_indicator),
	.counting_halt(counting_halt), .irq(irq));

// file: tb_ceru_top.sv
`timescale 1ns/1ps

module tb_ceru_top;
	import ceru_pkg::*;

	logic        clk_sys = 1'b0;
	logic        rstn = 1'b0;
	logic [4:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        unit_restart = 1'b0;
	logic        init_done = 1'b0;
	logic        unit_number_bad = 1'b0;
	logic        cyclic_init_fault = 1'b0;
	logic        unit_type_wrong = 1'b0;
	logic        watchdog_expired = 1'b0;
	logic        host_fault = 1'b0;
	logic        fault_report = 1'b0;
	logic [1:0]  fault_category = 2'h0;
	logic [15:0] fault_code_primary = 16'h0000;
	logic [15:0] fault_code_secondary = 16'h0000;
	logic        fault_removed = 1'b0;
	logic        run_indicator;
	logic        unit_fault_indicator;
	logic        host_fault_indicator;
	logic        counting_halt;
	logic        irq;
	logic [31:0] rd;
	int          errors = 0;
	int          cmp_count = 0;

	always #4 clk_sys = ~clk_sys;

	ceru_host host_u (.clk_sys(clk_sys), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

	ceru_top #(.DEPTH(LOG_DEPTH)) dut_u (.clk_sys(clk_sys), .rstn(rstn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.unit_restart(unit_restart), .init_done(init_done), .unit_number_bad(unit_number_bad),
		.cyclic_init_fault(cyclic_init_fault), .unit_type_wrong(unit_type_wrong),
		.watchdog_expired(watchdog_expired), .host_fault(host_fault), .fault_report(fault_report),
		.fault_category(fault_category), .fault_code_primary(fault_code_primary),
		.fault_code_secondary(fault_code_secondary), .fault_removed(fault_removed),
		.run_indicator(run_indicator), .unit_fault_indicator(unit_fault_indicator),
		.host_fault_indicator(host_fault_indicator), .counting_halt(counting_halt), .irq(irq));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic ind(input string what, input logic [2:0] exp);
		repeat (4) @(posedge clk_sys);
		check(what, {29'h0, exp}, {29'h0, run_indicator, unit_fault_indicator, host_fault_indicator});
	endtask

	task automatic rreg(input logic [4:0] a);
		host_u.xfer(a, 1'b0, 32'h0000_0000, rd);
	endtask

	task automatic wreg(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		host_u.xfer(a, 1'b1, d, q);
	endtask

	task automatic do_reset(input logic run);
		@(posedge clk_sys);
		rstn <= 1'b0;
		init_done <= 1'b0;
		unit_number_bad <= 1'b0;
		cyclic_init_fault <= 1'b0;
		unit_type_wrong <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		init_done <= run;
		repeat (4) @(posedge clk_sys);
	endtask

	task automatic fire(input logic [1:0] cat, input logic [15:0] p, input logic [15:0] s);
		@(posedge clk_sys);
		fault_report <= 1'b1;
		fault_category <= cat;
		fault_code_primary <= p;
		fault_code_secondary <= s;
		@(posedge clk_sys);
		fault_report <= 1'b0;
		fault_code_primary <= ~p;
		fault_code_secondary <= ~s;
	endtask

	task automatic removed();
		@(posedge clk_sys);
		fault_removed <= 1'b1;
		@(posedge clk_sys);
		fault_removed <= 1'b0;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_init();
		do_reset(1'b0);
		rreg(ADDR_STATUS);
		check("status", 32'h0000_1010, rd);
		rreg(5'h18);
		check("unmapped", RD_UNMAPPED, rd);
		rreg(ADDR_IRQ_MASK);
		check("mask", {28'h0, IRQ_MASK_RESET}, rd);
		unit_number_bad <= 1'b1;
		ind("unit number", 3'b001);
		do_reset(1'b0);
		cyclic_init_fault <= 1'b1;
		ind("cyclic", 3'b001);
		do_reset(1'b0);
		unit_type_wrong <= 1'b1;
		ind("unit type", 3'b011);
		do_reset(1'b0);
		fire(CAT_CONFIG, 16'h0310, 16'h0012);
		ind("config", 3'b010);
		check("halt", 32'h1, {31'h0, counting_halt});
		rreg(ADDR_ERROR_CODE);
		check("config codes", 32'h0012_0310, rd);
		removed();
		rreg(ADDR_STATUS);
		check("halted flag", 32'h1, {31'h0, rd[STAT_GLOBAL_ERR]});
		$display("t_init done");
	endtask

	task automatic t_run();
		do_reset(1'b1);
		ind("running", 3'b100);
		fire(CAT_OVERFLOW, 16'h0100, 16'h0001);
		ind("overflow", 3'b110);
		rreg(ADDR_ERROR_CODE);
		check("codes", 32'h0001_0100, rd);
		rreg(ADDR_STATUS);
		check("flag", 32'h1, {31'h0, rd[STAT_GLOBAL_ERR]});
		removed();
		ind("removed", 3'b100);
		rreg(ADDR_STATUS);
		check("flag off", 32'h0, {31'h0, rd[STAT_GLOBAL_ERR]});
		rreg(ADDR_ERROR_CODE);
		check("codes off", 32'h0, rd);
		host_fault <= 1'b1;
		ind("host", 3'b101);
		host_fault <= 1'b0;
		repeat (4) @(posedge clk_sys);
		for (int c = 2; c < 4; c++)
		begin
			fire(c[1:0], 16'h0400 + 16'(c), 16'h0000);
			ind("category", 3'b110);
			rreg(ADDR_STATUS);
			check("category", 32'(c), 32'(rd[9:8]));
			removed();
		end
		$display("t_run done");
	endtask

	task automatic t_log();
		logic [31:0] exp;
		do_reset(1'b1);
		for (int i = 0; i <= LOG_DEPTH; i++)
			fire(CAT_OVERFLOW, 16'h1000 + 16'(i), 16'h2000 + 16'(i));
		rreg(ADDR_LOG_COUNT);
		check("log count", 32'(LOG_DEPTH), rd);
		rreg(ADDR_IRQ_STATUS);
		check("log full event", 32'h0000_0005, rd);
		for (int k = 0; k < LOG_DEPTH + 2; k++)
		begin
			host_u.advance();
			repeat (2) @(posedge clk_sys);
			exp = (k < LOG_DEPTH) ? {16'h2000 + 16'(k), 16'h1000 + 16'(k)} : 32'h0000_0000;
			if (k == LOG_DEPTH + 1)
				exp = 32'h2000_1000;
			rreg(ADDR_ERROR_CODE);
			check("log entry", exp, rd);
		end
		@(posedge clk_sys);
		unit_restart <= 1'b1;
		@(posedge clk_sys);
		unit_restart <= 1'b0;
		rreg(ADDR_LOG_COUNT);
		check("log cleared", 32'h0, rd);
		$display("t_log done");
	endtask

	task automatic t_irq();
		do_reset(1'b1);
		wreg(ADDR_IRQ_MASK, 32'h0000_0001);
		check("irq idle", 32'h0, {31'h0, irq});
		fire(CAT_PRESET, 16'h0500, 16'h0001);
		repeat (4) @(posedge clk_sys);
		check("irq set", 32'h1, {31'h0, irq});
		wreg(ADDR_IRQ_MASK, 32'h0000_0000);
		repeat (2) @(posedge clk_sys);
		check("irq masked", 32'h0, {31'h0, irq});
		wreg(ADDR_IRQ_MASK, 32'h0000_0001);
		wreg(ADDR_IRQ_STATUS, 32'h0000_000f);
		repeat (2) @(posedge clk_sys);
		check("irq cleared", 32'h0, {31'h0, irq});
		removed();
		rreg(ADDR_IRQ_STATUS);
		check("irq removal", 32'h0000_0002, rd);
		check("irq unmasked", 32'h0, {31'h0, irq});
		$display("t_irq done");
	endtask

	task automatic t_wdog();
		@(posedge clk_sys);
		watchdog_expired <= 1'b1;
		@(posedge clk_sys);
		watchdog_expired <= 1'b0;
		ind("watchdog", 3'b000);
		check("wdog halt", 32'h1, {31'h0, counting_halt});
		rreg(ADDR_IRQ_STATUS);
		check("wdog event", 32'h0000_000a, rd);
		unit_restart <= 1'b1;
		@(posedge clk_sys);
		unit_restart <= 1'b0;
		ind("watchdog held", 3'b000);
		$display("t_wdog done");
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial
	begin
		#400000;
		errors++;
		close_out();
	end

	initial
	begin
		t_init();
		t_run();
		t_log();
		t_irq();
		t_wdog();
		close_out();
	end
endmodule
